// ===== verilog/eprc_cfg.svh
// Constants of the encoder position regulator block.
// Assumes inclusion by bare name from every design file that needs them.
// Notes on behaviour
// - With gating clear, errors smaller in magnitude than the tolerance are ignored.
// - With gating set (reset value), small errors are ignored only while target is reached.
// - An 8-bit tolerance resets to zero; errors strictly below it count as no error.
// - A 10-bit unsigned gain of zero disables the regulator, nonzero enables it.
// - The encoder position is a signed 32-bit software read/write value, reset to zero.
// - A 2-bit select picks the back-EMF input filter, clock over 24600/12300/6150/2870.
// - Blanking lasts the 8-bit setting times (2^14 - 1) clocks; the setting resets to 0x10.
// - With quiescence enable clear both decoders stop in quiescence; set (default) they run.
// - Source select picks back-EMF full-step decoding at 0, quadrature interface at 1.
`ifndef EPRC_CFG_SVH
`define EPRC_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define EPRC_CLK_HZ 20000000
`define EPRC_BLANK_UNIT 16383
`define EPRC_BLANK_CNT_W 22
`define EPRC_FILT_DIV0 24600
`define EPRC_FILT_DIV1 12300
`define EPRC_FILT_DIV2 6150
`define EPRC_FILT_DIV3 2870
`define EPRC_FILT_CNT_W 15

// ----------------------------------------
// Register indices, byte address is four times
// ----------------------------------------
`define EPRC_ADDR_W 10
`define EPRC_IDX_PCTRL 8'h62
`define EPRC_IDX_XENC 8'h63
`define EPRC_IDX_MODE 8'h64

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define EPRC_GAIN_LSB 0
`define EPRC_GAIN_W 10
`define EPRC_TOL_LSB 16
`define EPRC_TOL_W 8
`define EPRC_ENTOL_BIT 28
`define EPRC_FILT_LSB 28
`define EPRC_FILT_W 2
`define EPRC_BLANK_LSB 16
`define EPRC_BLANK_W 8
`define EPRC_QSC_BIT 15
`define EPRC_SRC_BIT 11
`define EPRC_REACHED_BIT 9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPRC_GAIN_RST 10'h000
`define EPRC_TOL_RST 8'h00
`define EPRC_ENTOL_RST 1'h1
`define EPRC_POS_RST 32'h0000_0000
`define EPRC_FILT_RST 2'h0
`define EPRC_BLANK_RST 8'h10
`define EPRC_QSC_RST 1'h1
`define EPRC_SRC_RST 1'h0

`endif

// ===== verilog/eprc_pkg.sv
// Types shared by the encoder position regulator files.
// Assumes nothing of its surroundings.
package eprc_pkg;
  typedef logic [31:0] eprc_word_t;
  typedef logic signed [31:0] eprc_pos_t;
  typedef logic signed [43:0] eprc_corr_t;
endpackage

// ===== verilog/eprc_step_if.sv
// Step event carrier from a decoder to the position counter.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface eprc_step_if;
  logic step;
  logic up;
  modport src (output step, output up);
  modport snk (input step, input up);
endinterface

// ===== verilog/eprc_lpf.sv
// Per-bit stability filter for the back-EMF comparator inputs.
// Assumes inputs already synchronised to clk.
`timescale 1ns/1ps
module eprc_lpf #(
  parameter int WIDTH = 2,
  parameter int CNT_W = 15
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic [WIDTH-1:0] din, // raw level
  input wire logic [CNT_W-1:0] limit, // stable cycles needed
  output logic [WIDTH-1:0] dout // filtered level
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gBit
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;
      logic out_r;
      logic out_nxt;
      always_comb begin
        cnt_nxt = '0;
        out_nxt = out_r;
        if (din[g] != out_r) begin
          // Change accepted only after a full time constant
          if (cnt_r >= limit - CNT_W'(1)) begin
            out_nxt = din[g];
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          cnt_r <= '0;
          out_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          out_r <= out_nxt;
        end
      end
      assign dout[g] = out_r;
    end
  endgenerate
endmodule

// ===== verilog/eprc_quad.sv
// Two-channel quadrature step decoder, one step per valid edge.
// Assumes stable, synchronised channel levels on clk.
`timescale 1ns/1ps
module eprc_quad (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic enable, // decoder running
  input wire logic chA, // channel A level
  input wire logic chB, // channel B level
  eprc_step_if.src stepOut // step events
);
  logic [1:0] prev_r;
  logic [1:0] prev_nxt;
  logic primed_r;
  logic primed_nxt;
  logic step_r;
  logic step_nxt;
  logic up_r;
  logic up_nxt;
  always_comb begin
    prev_nxt = {chA, chB};
    primed_nxt = 1'b1;
    // Double changes are skipped, they carry no direction
    step_nxt = enable & primed_r & (^(prev_r ^ {chA, chB}));
    up_nxt = chA ^ prev_r[0];
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= 2'h0;
      primed_r <= 1'b0;
      step_r <= 1'b0;
      up_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      primed_r <= primed_nxt;
      step_r <= step_nxt;
      up_r <= up_nxt;
    end
  end
  assign stepOut.step = step_r;
  assign stepOut.up = up_r;
endmodule

// ===== verilog/eprc_top.sv
// Encoder feedback and proportional position regulator for one axis.
// Assumes an Avalon-MM master on clk and raw encoder or back-EMF pins.
`timescale 1ns/1ps
`include "eprc_cfg.svh"
module eprc_top #(
  parameter int BLANK_UNIT = `EPRC_BLANK_UNIT,
  parameter int FILT_DIV0 = `EPRC_FILT_DIV0,
  parameter int FILT_DIV1 = `EPRC_FILT_DIV1,
  parameter int FILT_DIV2 = `EPRC_FILT_DIV2,
  parameter int FILT_DIV3 = `EPRC_FILT_DIV3
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic [`EPRC_ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire eprc_pkg::eprc_word_t avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output eprc_pkg::eprc_word_t avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire eprc_pkg::eprc_pos_t rampPos, // ramp position
  input wire eprc_pkg::eprc_word_t rampStatusWord, // ramp status
  input wire logic regUpdate, // regulator update pulse
  input wire logic quiescent, // quiescence mode
  input wire logic blankStart, // start blanking pulse
  input wire logic incA, // quadrature pin A
  input wire logic incB, // quadrature pin B
  input wire logic bemfA, // back-EMF comparator A
  input wire logic bemfB, // back-EMF comparator B
  output eprc_pkg::eprc_corr_t regCorrection, // scaled error
  output logic regEnabled, // gain nonzero
  output logic errIgnored, // last error ignored
  output eprc_pkg::eprc_pos_t encPosition, // encoder count
  output logic bemfBlanked, // blanking active
  output logic decoderActive // decoders running
);
  import eprc_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pinRaw;
  logic [3:0] pinStable;
  assign pinRaw = {bemfB, bemfA, incB, incA};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gSync
      logic [2:0] sh_r;
      logic [2:0] sh_nxt;
      logic st_r;
      logic st_nxt;
      always_comb begin
        sh_nxt = {sh_r[1:0], pinRaw[g]};
        // Only stages two and three vote
        st_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : st_r;
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          sh_r <= 3'h0;
          st_r <= 1'b0;
        end else begin
          sh_r <= sh_nxt;
          st_r <= st_nxt;
        end
      end
      assign pinStable[g] = st_r;
    end
  endgenerate

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [`EPRC_GAIN_W-1:0] gain_r;
  logic [`EPRC_GAIN_W-1:0] gain_nxt;
  logic [`EPRC_TOL_W-1:0] tol_r;
  logic [`EPRC_TOL_W-1:0] tol_nxt;
  logic enTol_r;
  logic enTol_nxt;
  logic [`EPRC_FILT_W-1:0] filtSel_r;
  logic [`EPRC_FILT_W-1:0] filtSel_nxt;
  logic [`EPRC_BLANK_W-1:0] blank_r;
  logic [`EPRC_BLANK_W-1:0] blank_nxt;
  logic qscEn_r;
  logic qscEn_nxt;
  logic srcSel_r;
  logic srcSel_nxt;
  eprc_pos_t pos_r;
  eprc_pos_t pos_nxt;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack_r;
  logic ack_nxt;
  eprc_word_t readData_r;
  eprc_word_t readData_nxt;
  logic [7:0] regIdx;
  logic wrEn;
  eprc_word_t ctrlWord;
  eprc_word_t modeWord;
  eprc_word_t rdMux;
  eprc_word_t wrMerged;

  function automatic eprc_word_t beMerge(input eprc_word_t old, input eprc_word_t nw,
                                         input logic [3:0] be);
    eprc_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign regIdx = avs_address[`EPRC_ADDR_W-1:2];
  // One wait state: the reply is registered before waitrequest drops
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wrEn = avs_write & ack_r;

  always_comb begin
    ctrlWord = '0;
    ctrlWord[`EPRC_ENTOL_BIT] = enTol_r;
    ctrlWord[`EPRC_TOL_LSB +: `EPRC_TOL_W] = tol_r;
    ctrlWord[`EPRC_GAIN_LSB +: `EPRC_GAIN_W] = gain_r;
    modeWord = '0;
    modeWord[`EPRC_FILT_LSB +: `EPRC_FILT_W] = filtSel_r;
    modeWord[`EPRC_BLANK_LSB +: `EPRC_BLANK_W] = blank_r;
    modeWord[`EPRC_QSC_BIT] = qscEn_r;
    modeWord[`EPRC_SRC_BIT] = srcSel_r;
    case (regIdx)
      `EPRC_IDX_PCTRL: rdMux = ctrlWord;
      `EPRC_IDX_XENC: rdMux = pos_r;
      `EPRC_IDX_MODE: rdMux = modeWord;
      default: rdMux = '0;
    endcase
    wrMerged = beMerge(rdMux, avs_writedata, avs_byteenable);
  end

  always_comb begin
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    readData_nxt = readData_r;
    if (avs_read & ~ack_r) begin
      readData_nxt = rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      readData_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      readData_r <= readData_nxt;
    end
  end
  assign avs_readdata = readData_r;

  // ----------------------------------------
  // Back-EMF filter and blanking
  // ----------------------------------------
  logic decEn;
  logic [`EPRC_FILT_CNT_W-1:0] filtLimit;
  logic [1:0] bemfFilt;
  logic [`EPRC_BLANK_CNT_W-1:0] blankCnt_r;
  logic [`EPRC_BLANK_CNT_W-1:0] blankCnt_nxt;

  // Decoders sleep in quiescence unless kept alive
  assign decEn = ~(quiescent & ~qscEn_r);

  always_comb begin
    case (filtSel_r)
      2'h0: filtLimit = `EPRC_FILT_CNT_W'(FILT_DIV0);
      2'h1: filtLimit = `EPRC_FILT_CNT_W'(FILT_DIV1);
      2'h2: filtLimit = `EPRC_FILT_CNT_W'(FILT_DIV2);
      2'h3: filtLimit = `EPRC_FILT_CNT_W'(FILT_DIV3);
      default: filtLimit = `EPRC_FILT_CNT_W'(FILT_DIV0);
    endcase
  end

  eprc_lpf #(
    .WIDTH(2),
    .CNT_W(`EPRC_FILT_CNT_W)
  ) uLpf (
    .clk(clk),
    .rst(rst),
    .din(pinStable[3:2]),
    .limit(filtLimit),
    .dout(bemfFilt)
  );

  always_comb begin
    blankCnt_nxt = blankCnt_r;
    if (blankStart) begin
      blankCnt_nxt = `EPRC_BLANK_CNT_W'(blank_r * BLANK_UNIT);
    end else if (blankCnt_r != '0) begin
      blankCnt_nxt = blankCnt_r - `EPRC_BLANK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      blankCnt_r <= '0;
    end else begin
      blankCnt_r <= blankCnt_nxt;
    end
  end

  // ----------------------------------------
  // Decoders and position counter
  // ----------------------------------------
  eprc_step_if incStep ();
  eprc_step_if bemfStep ();

  eprc_quad uIncQuad (
    .clk(clk),
    .rst(rst),
    .enable(decEn),
    .chA(pinStable[0]),
    .chB(pinStable[1]),
    .stepOut(incStep)
  );

  eprc_quad uBemfQuad (
    .clk(clk),
    .rst(rst),
    .enable(decEn & (blankCnt_r == '0)),
    .chA(bemfFilt[0]),
    .chB(bemfFilt[1]),
    .stepOut(bemfStep)
  );

  logic selStep;
  logic selUp;
  assign selStep = srcSel_r ? incStep.step : bemfStep.step;
  assign selUp = srcSel_r ? incStep.up : bemfStep.up;

  always_comb begin
    gain_nxt = gain_r;
    tol_nxt = tol_r;
    enTol_nxt = enTol_r;
    filtSel_nxt = filtSel_r;
    blank_nxt = blank_r;
    qscEn_nxt = qscEn_r;
    srcSel_nxt = srcSel_r;
    pos_nxt = pos_r;
    if (selStep) begin
      pos_nxt = selUp ? pos_r + 32'sd1 : pos_r - 32'sd1;
    end
    if (wrEn) begin
      case (regIdx)
        `EPRC_IDX_PCTRL: begin
          gain_nxt = wrMerged[`EPRC_GAIN_LSB +: `EPRC_GAIN_W];
          tol_nxt = wrMerged[`EPRC_TOL_LSB +: `EPRC_TOL_W];
          enTol_nxt = wrMerged[`EPRC_ENTOL_BIT];
        end
        `EPRC_IDX_XENC: begin
          // Software load beats a decoder step in the same cycle
          pos_nxt = wrMerged;
        end
        `EPRC_IDX_MODE: begin
          filtSel_nxt = wrMerged[`EPRC_FILT_LSB +: `EPRC_FILT_W];
          blank_nxt = wrMerged[`EPRC_BLANK_LSB +: `EPRC_BLANK_W];
          qscEn_nxt = wrMerged[`EPRC_QSC_BIT];
          srcSel_nxt = wrMerged[`EPRC_SRC_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_r <= `EPRC_GAIN_RST;
      tol_r <= `EPRC_TOL_RST;
      enTol_r <= `EPRC_ENTOL_RST;
      filtSel_r <= `EPRC_FILT_RST;
      blank_r <= `EPRC_BLANK_RST;
      qscEn_r <= `EPRC_QSC_RST;
      srcSel_r <= `EPRC_SRC_RST;
      pos_r <= `EPRC_POS_RST;
    end else begin
      gain_r <= gain_nxt;
      tol_r <= tol_nxt;
      enTol_r <= enTol_nxt;
      filtSel_r <= filtSel_nxt;
      blank_r <= blank_nxt;
      qscEn_r <= qscEn_nxt;
      srcSel_r <= srcSel_nxt;
      pos_r <= pos_nxt;
    end
  end

  // ----------------------------------------
  // Proportional regulator
  // ----------------------------------------
  logic signed [32:0] errFull;
  logic [32:0] errAbs;
  logic errSmall;
  logic tolGate;
  logic ignoreErr;
  eprc_corr_t product;
  eprc_corr_t corr_r;
  eprc_corr_t corr_nxt;
  logic ignored_r;
  logic ignored_nxt;

  always_comb begin
    // Widened by one bit so the difference never wraps
    errFull = {rampPos[31], rampPos} - {pos_r[31], pos_r};
    errAbs = errFull[32] ? 33'(-errFull) : 33'(errFull);
    errSmall = errAbs < {25'h000_0000, tol_r};
    tolGate = enTol_r ? rampStatusWord[`EPRC_REACHED_BIT] : 1'b1;
    ignoreErr = tolGate & errSmall;
    product = 44'(errFull * $signed({1'b0, gain_r}));
    corr_nxt = corr_r;
    ignored_nxt = ignored_r;
    if (regUpdate) begin
      ignored_nxt = ignoreErr;
      corr_nxt = (gain_r == '0 || ignoreErr) ? '0 : product;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      corr_r <= '0;
      ignored_r <= 1'b0;
    end else begin
      corr_r <= corr_nxt;
      ignored_r <= ignored_nxt;
    end
  end

  assign regCorrection = corr_r;
  assign regEnabled = gain_r != '0;
  assign errIgnored = ignored_r;
  assign encPosition = pos_r;
  assign bemfBlanked = blankCnt_r != '0;
  assign decoderActive = decEn;
endmodule

// ===== tb/eprc_enc_model.sv
// Encoder pin model: two-channel gray code, one phase per step request.
// Assumes requests are one-cycle pulses on clk.
`timescale 1ns/1ps
module eprc_enc_model (
  input wire logic clk, // clock
  input wire logic stepReq, // step pulse
  input wire logic stepDir, // 1 forward
  output logic chA, // channel A
  output logic chB // channel B
);
  logic [1:0] phase_r = 2'h0;
  always_ff @(posedge clk) begin
    if (stepReq) begin
      phase_r <= stepDir ? phase_r + 2'h1 : phase_r - 2'h1;
    end
  end
  // Gray order 00,10,11,01: one channel changes per step
  assign chA = phase_r[0] ^ phase_r[1];
  assign chB = phase_r[1];
endmodule

// ===== tb/eprc_top_checker.sv
// Port-level checks of the regulator block.
// Assumes a bind to eprc_top; one clock, sync reset.
`timescale 1ns/1ps
module eprc_top_checker (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire eprc_pkg::eprc_word_t avs_readdata, // data
  input wire logic avs_waitrequest, // stall
  input wire eprc_pkg::eprc_pos_t rampPos, // ramp
  input wire logic regUpdate, // update
  input wire logic quiescent, // quiet
  input wire eprc_pkg::eprc_corr_t regCorrection, // output
  input wire logic regEnabled, // gain on
  input wire logic errIgnored, // ignored
  input wire eprc_pkg::eprc_pos_t encPosition, // count
  input wire logic bemfBlanked, // blank
  input wire logic decoderActive // running
);
  import eprc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_wait_first;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("access not answered");
  property p_rd_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
  property p_gain_off;
    regUpdate && !regEnabled |=> regCorrection == '0;
  endproperty
  a_gain_off: assert property (p_gain_off) else $error("output with gain zero");
  property p_ign_zero;
    errIgnored |-> regCorrection == '0;
  endproperty
  a_ign_zero: assert property (p_ign_zero) else $error("ignored error output");
  property p_corr_hold;
    !regUpdate |=> $stable(regCorrection) && $stable(errIgnored);
  endproperty
  a_corr_hold: assert property (p_corr_hold) else $error("output moved");
  property p_no_err;
    regUpdate && regEnabled && rampPos == encPosition |=> regCorrection == '0;
  endproperty
  a_no_err: assert property (p_no_err) else $error("output without error");
  property p_dec_on;
    !quiescent |-> decoderActive;
  endproperty
  a_dec_on: assert property (p_dec_on) else $error("decoder stopped");
  sequence s_stopped;
    !decoderActive [*3] ##0 !avs_write;
  endsequence
  property p_pos_frozen;
    s_stopped |=> $stable(encPosition);
  endproperty
  a_pos_frozen: assert property (p_pos_frozen) else $error("count while stopped");
  c_ignored: cover property (regUpdate ##1 errIgnored);
  c_blank: cover property ($rose(bemfBlanked));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule

// ===== tb/eprc_top_tb.sv
// Register, regulator, encoder and blanking tests of eprc_top.
// Assumes shortened filter and blanking counts set below.
`timescale 1ns/1ps
module eprc_top_tb;
  import eprc_pkg::*;
  localparam int BU = 3;
  localparam int DIVS [4] = '{8, 6, 4, 2};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  eprc_word_t avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  eprc_word_t avs_readdata, rampStatusWord = 32'h0000_0000, rd;
  eprc_pos_t rampPos = 32'h0000_0000;
  eprc_pos_t encPosition;
  eprc_corr_t regCorrection;
  logic avs_waitrequest, regEnabled, errIgnored, bemfBlanked, decoderActive;
  logic incA, incB, bemfA, bemfB;
  logic regUpdate = 1'b0, quiescent = 1'b0, blankStart = 1'b0;
  logic incReq = 1'b0, bemfReq = 1'b0, stepDir = 1'b0;
  logic [3:0] wrBe = 4'hf;
  int numErrors = 0;
  int nCompared = 0;
  always #25 clk = ~clk;
  eprc_top #(.BLANK_UNIT(BU), .FILT_DIV0(8), .FILT_DIV1(6), .FILT_DIV2(4), .FILT_DIV3(2))
    eprc_top_inst (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rampPos, .rampStatusWord, .regUpdate,
    .quiescent, .blankStart, .incA, .incB, .bemfA, .bemfB, .regCorrection, .regEnabled,
    .errIgnored, .encPosition, .bemfBlanked, .decoderActive);
  eprc_enc_model eprc_enc_model_inst (.clk, .stepReq(incReq), .stepDir, .chA(incA), .chB(incB));
  eprc_enc_model eprc_enc_model_inst_b (.clk, .stepReq(bemfReq), .stepDir, .chA(bemfA),
    .chB(bemfB));
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] g);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [9:0] a, input eprc_word_t d);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= wr ? wrBe : 4'h0;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] a, input eprc_word_t e);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), 44'(e), 44'(rd));
  endtask
  function automatic eprc_word_t mode(input int sel, input int b, input logic q, input logic s);
    return {2'b00, 2'(sel), 4'h0, 8'(b), q, 3'b000, s, 11'h000};
  endfunction
  task automatic step(input logic bemf, input logic dir);
    @(posedge clk);
    incReq <= ~bemf;
    bemfReq <= bemf;
    stepDir <= dir;
    @(posedge clk);
    incReq <= 1'b0;
    bemfReq <= 1'b0;
  endtask
  task automatic waitPos(input eprc_pos_t e);
    for (int i = 0; i < 40 && encPosition !== e; i++) @(posedge clk);
    chk("encPosition", 44'(e), 44'(encPosition));
  endtask
  // Tolerance 5, encoder position 100 throughout
  task automatic upd(input int gain, input int gate, input int reach, input int ramp);
    int e;
    logic ig;
    logic signed [43:0] ec;
    bus(1'b1, 10'h188, {3'b000, 1'(gate), 4'h0, 8'h05, 6'h00, 10'(gain)});
    e = ramp - 100;
    ig = (gate != 0 ? reach != 0 : 1'b1) && e < 5 && e > -5;
    ec = (gain == 0 || ig) ? 44'h000_0000_0000 : 44'(e * gain);
    @(posedge clk);
    rampPos <= ramp;
    rampStatusWord <= 32'(reach) << 9;
    regUpdate <= 1'b1;
    @(posedge clk);
    regUpdate <= 1'b0;
    @(negedge clk);
    chk("regCorrection", ec, regCorrection);
    chk("errIgnored", 44'(ig), 44'(errIgnored));
    chk("regEnabled", 44'(gain != 0), 44'(regEnabled));
  endtask
  // A five-cycle pulse on one channel passes only short filters
  task automatic glitch(input int sel);
    eprc_pos_t p0;
    logic moved;
    bus(1'b1, 10'h190, mode(sel, 0, 1'b1, 1'b0));
    repeat (20) @(posedge clk);
    p0 = encPosition;
    moved = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      bemfReq <= (i == 0 || i == 5);
      stepDir <= (i == 0);
      if (encPosition !== p0) moved = 1'b1;
    end
    chk("filtered step", 44'(DIVS[sel] < 5), 44'(moved));
    chk("encPosition", 44'(p0), 44'(encPosition));
  endtask
  task automatic blankTest(input int b);
    int n;
    bus(1'b1, 10'h190, mode(0, b, 1'b1, 1'b0));
    n = 0;
    @(posedge clk);
    blankStart <= 1'b1;
    @(posedge clk);
    blankStart <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (bemfBlanked === 1'b1) n++;
    end
    chk("blank cycles", 44'(b * BU), 44'(n));
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    $display("Error watchdog expected end seen hang");
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(10'h188, 32'h1000_0000);
    rchk(10'h18C, 32'h0000_0000);
    rchk(10'h190, 32'h0010_8000);
    bus(1'b1, 10'h000, 32'hFFFF_FFFF);
    rchk(10'h000, 32'h0000_0000);
    rchk(10'h194, 32'h0000_0000);
    bus(1'b1, 10'h190, 32'hFFFF_FFFF);
    rchk(10'h190, 32'h30FF_8800);
    bus(1'b1, 10'h18C, 32'h8000_0001);
    rchk(10'h18C, 32'h8000_0001);
    // Only the low byte lane may change
    wrBe = 4'h1;
    bus(1'b1, 10'h18C, 32'hAAAA_AA55);
    wrBe = 4'hf;
    rchk(10'h18C, 32'h8000_0055);
    $display("registers done");
    bus(1'b1, 10'h18C, 32'h0000_0064);
    upd(0, 0, 0, 200);
    upd(3, 0, 0, 104);
    upd(3, 0, 0, 105);
    upd(3, 0, 0, 96);
    upd(3, 0, 0, 95);
    upd(3, 1, 0, 104);
    upd(3, 1, 1, 104);
    upd(1023, 1, 1, 90);
    upd(3, 0, 0, 100);
    upd(3, 1, 0, 100);
    $display("regulator done");
    bus(1'b1, 10'h190, mode(0, 0, 1'b1, 1'b1));
    bus(1'b1, 10'h18C, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      step(1'b0, i != 3);
      waitPos(i == 3 ? 2 : i + 1);
    end
    @(posedge clk);
    quiescent <= 1'b1;
    @(negedge clk);
    chk("decoderActive", 44'(1), 44'(decoderActive));
    bus(1'b1, 10'h190, mode(0, 0, 1'b0, 1'b1));
    @(negedge clk);
    chk("decoderActive", 44'(0), 44'(decoderActive));
    step(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    chk("encPosition", 44'(2), 44'(encPosition));
    quiescent <= 1'b0;
    $display("quadrature done");
    for (int s = 0; s < 4; s++) glitch(s);
    bus(1'b1, 10'h18C, 32'h0000_0007);
    step(1'b1, 1'b1);
    waitPos(8);
    blankTest(4);
    blankTest(0);
    $display("back-EMF done");
    conclude();
  end
endmodule
bind eprc_top eprc_top_checker eprc_top_checker_inst (.clk, .rst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .rampPos, .regUpdate, .quiescent, .regCorrection,
  .regEnabled, .errIgnored, .encPosition, .bemfBlanked, .decoderActive);
